// ### src/wfm_pkg.sv
package wfm_pkg;
  localparam int          SAMPLE_W  = 12;
  localparam int          CYC_W     = 25;
  localparam logic [24:0] CYC_MAX   = 25'h1000000;
  localparam int          DIV_W     = 24;
  localparam int          ADDR_W    = 5;
  // register byte addresses
  localparam logic [4:0]  A_CTRL    = 5'h00;
  localparam logic [4:0]  A_STAT    = 5'h04;
  localparam logic [4:0]  A_CYC     = 5'h08;
  localparam logic [4:0]  A_DIV     = 5'h0C;
  localparam logic [4:0]  A_DATA    = 5'h10;
  localparam logic [4:0]  A_CNT     = 5'h14;
  // control bits
  localparam int          B_START   = 0;
  localparam int          B_CLEAR   = 1;
  localparam int          B_EXT     = 2;
  localparam int          B_REF     = 3;
  localparam int          B_DBUF    = 4;
  localparam int          B_FLUSH   = 5;
  // status bits
  localparam int          S_RUN     = 0;
  localparam int          S_DONE    = 1;
  localparam int          S_ERR     = 2;
  localparam int          S_OVF     = 3;
  localparam int          S_LCNT    = 8;
  // default internal update period
  localparam int          CLK_NS    = 10;
  localparam int          UPD_NS    = 1000;
  localparam logic [23:0] DIV_RST   = 24'(UPD_NS / CLK_NS - 1);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SHIFT = 2'b11
  } eng_state_t;
endpackage : wfm_pkg

// ### src/cyclic_waveform_playback.sv
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    rd_r;
  logic [CW-1:0]    cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - There are NUM_CH output channels (four or eight), numbered from 0, each with its own code.
// - Each channel takes a 12-bit code that is always treated as bipolar, with no unipolar mode.
// - A control bit selects the internal +10 V or an external reference for the outputs.
// - Samples are loaded into the waveform memory once and replayed endlessly or N times.
// - Once playback runs it needs no further host transfers or servicing to keep going.
// - The cycle count is 0 for endless playback or 1 to 16,777,216; other values are refused.
// - Each update is paced by the internal counter or by the external update pin, as selected.
// - Endless playback runs until the host writes the clear command.
// - A cycle counter apart from the update source stops playback after the programmed count.
module cyclic_waveform_playback #(
  parameter int NUM_CH     = 8,
  parameter int WAVE_DEPTH = 64,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // avalon-mm slave
  input  wire logic [wfm_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // update pin
  input  wire logic                       ext_update,
  // converters
  output logic [NUM_CH*wfm_pkg::SAMPLE_W-1:0] dac_code,
  output logic                            dac_load,
  output logic                            ref_ext_sel
);
  localparam int SW = wfm_pkg::SAMPLE_W;
  localparam int LW = $clog2(WAVE_DEPTH);
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam logic [LW:0]     MEM_FULL = (LW+1)'(WAVE_DEPTH);
  localparam logic [CH_W-1:0] CH_LAST  = CH_W'(NUM_CH - 1);

  wfm_pkg::eng_state_t state_r;
  logic [SW-1:0]       wave_r [WAVE_DEPTH];
  logic [SW-1:0]       hold_r [NUM_CH];
  logic [LW:0]         lcnt_r;
  logic [LW-1:0]       rd_ptr_r;
  logic [CH_W-1:0]     ch_r;
  logic [wfm_pkg::CYC_W-1:0] cycles_r;
  logic [wfm_pkg::CYC_W-1:0] cyc_cnt_r;
  logic [wfm_pkg::DIV_W-1:0] div_r;
  logic [wfm_pkg::DIV_W-1:0] div_cnt_r;
  logic                stop_pend_r;
  logic                last_r;
  logic                dac_load_r;
  logic                ext_sel_r;
  logic                ref_sel_r;
  logic                dbuf_r;
  logic                done_r;
  logic                err_r;
  logic                ovf_r;
  logic                rd_ack_r;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;
  logic                ext_s1_r;
  logic                ext_s2_r;
  logic                ext_d_r;
  logic                wr_ctrl;
  logic                wr_data;
  logic                start_req;
  logic                clear_req;
  logic                start_ok;
  logic                upd;
  logic                upd_int;
  logic                wrap;
  logic                hit_end;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_pop;
  logic [SW-1:0]       fifo_out_data;
  logic                cyc_ok;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  assign wr_ctrl   = avs_write && (avs_address == wfm_pkg::A_CTRL);
  assign wr_data   = avs_write && (avs_address == wfm_pkg::A_DATA);
  assign start_req = wr_ctrl && avs_writedata[wfm_pkg::B_START];
  assign clear_req = wr_ctrl && avs_writedata[wfm_pkg::B_CLEAR];
  // odd counts and double-buffer mode are refused at start
  assign start_ok  = start_req && !clear_req && (state_r == wfm_pkg::ST_IDLE)
                     && (lcnt_r != '0) && !lcnt_r[0] && !dbuf_r;
  assign cyc_ok    = (avs_writedata[31:wfm_pkg::CYC_W] == '0)
                     && (avs_writedata[wfm_pkg::CYC_W-1:0] <= wfm_pkg::CYC_MAX);

  // a sample write stalls while the staging fifo is full
  assign avs_waitrequest = (avs_read && !rd_ack_r) || (wr_data && !fifo_in_ready);
  assign avs_readdata    = rdata_r;

  always_comb begin
    rdata_nxt = 32'h00000000;
    case (avs_address)
      wfm_pkg::A_CTRL: begin
        rdata_nxt[wfm_pkg::B_EXT]  = ext_sel_r;
        rdata_nxt[wfm_pkg::B_REF]  = ref_sel_r;
        rdata_nxt[wfm_pkg::B_DBUF] = dbuf_r;
      end
      wfm_pkg::A_STAT: begin
        rdata_nxt[wfm_pkg::S_RUN]  = (state_r != wfm_pkg::ST_IDLE);
        rdata_nxt[wfm_pkg::S_DONE] = done_r;
        rdata_nxt[wfm_pkg::S_ERR]  = err_r;
        rdata_nxt[wfm_pkg::S_OVF]  = ovf_r;
        rdata_nxt[wfm_pkg::S_LCNT +: LW+1] = lcnt_r;
      end
      wfm_pkg::A_CYC:  rdata_nxt[wfm_pkg::CYC_W-1:0] = cycles_r;
      wfm_pkg::A_DIV:  rdata_nxt[wfm_pkg::DIV_W-1:0] = div_r;
      wfm_pkg::A_CNT:  rdata_nxt[wfm_pkg::CYC_W-1:0] = cyc_cnt_r;
      default:         rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack_r <= 1'b0;
      rdata_r  <= 32'h00000000;
    end else begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sel_r <= 1'b0;
      ref_sel_r <= 1'b0;
      dbuf_r    <= 1'b0;
      cycles_r  <= '0;
      div_r     <= wfm_pkg::DIV_RST;
    end else begin
      if (wr_ctrl) begin
        ext_sel_r <= avs_writedata[wfm_pkg::B_EXT];
        ref_sel_r <= avs_writedata[wfm_pkg::B_REF];
        dbuf_r    <= avs_writedata[wfm_pkg::B_DBUF];
      end
      // out-of-range counts leave the old value in place
      if (avs_write && (avs_address == wfm_pkg::A_CYC) && cyc_ok) begin
        cycles_r <= avs_writedata[wfm_pkg::CYC_W-1:0];
      end
      if (avs_write && (avs_address == wfm_pkg::A_DIV)) begin
        div_r <= avs_writedata[wfm_pkg::DIV_W-1:0];
      end
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
      ovf_r  <= 1'b0;
    end else begin
      if (state_r == wfm_pkg::ST_SHIFT && ch_r == CH_LAST && hit_end) begin
        done_r <= 1'b1;
      end else if (start_ok || (avs_write && avs_address == wfm_pkg::A_STAT
                                && avs_writedata[wfm_pkg::S_DONE])) begin
        done_r <= 1'b0;
      end
      if ((start_req && !start_ok && !clear_req)
          || (avs_write && avs_address == wfm_pkg::A_CYC && !cyc_ok)) begin
        err_r <= 1'b1;
      end else if (avs_write && avs_address == wfm_pkg::A_STAT
                   && avs_writedata[wfm_pkg::S_ERR]) begin
        err_r <= 1'b0;
      end
      if (fifo_pop && lcnt_r == MEM_FULL) begin
        ovf_r <= 1'b1;
      end else if (avs_write && avs_address == wfm_pkg::A_STAT
                   && avs_writedata[wfm_pkg::S_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staging fifo and waveform memory

  sample_fifo #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (wr_data),
    .in_data   (avs_writedata[SW-1:0]),
    .in_ready  (fifo_in_ready),
    .out_ready (state_r == wfm_pkg::ST_IDLE),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data)
  );

  // memory is frozen while playing, so the fifo backs up to the bus
  assign fifo_pop = fifo_out_valid && (state_r == wfm_pkg::ST_IDLE);

  always_ff @(posedge sys_clk) begin
    if (fifo_pop && lcnt_r != MEM_FULL) begin
      wave_r[lcnt_r[LW-1:0]] <= fifo_out_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lcnt_r <= '0;
    end else if (wr_ctrl && avs_writedata[wfm_pkg::B_FLUSH]
                 && state_r == wfm_pkg::ST_IDLE) begin
      lcnt_r <= '0;
    end else if (fifo_pop && lcnt_r != MEM_FULL) begin
      lcnt_r <= lcnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // update sources

  // only the second stage feeds the edge detector
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r  <= 1'b0;
    end else begin
      ext_s1_r <= ext_update;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= wfm_pkg::DIV_RST;
    end else if (state_r == wfm_pkg::ST_IDLE || div_cnt_r == '0) begin
      div_cnt_r <= div_r;
    end else begin
      div_cnt_r <= div_cnt_r - 1'b1;
    end
  end

  assign upd_int = (state_r != wfm_pkg::ST_IDLE) && (div_cnt_r == '0);
  assign upd     = ext_sel_r ? (ext_s2_r && !ext_d_r) : upd_int;

  ////////////////////////////////////////////////////////////////////////////
  // playback engine

  assign wrap    = ({1'b0, rd_ptr_r} == lcnt_r - 1'b1);
  assign hit_end = stop_pend_r || (wrap && cycles_r != '0
                   && cyc_cnt_r + 1'b1 == cycles_r);

  // updates arriving mid-shift are dropped; pace them at least NUM_CH+1 clocks apart
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= wfm_pkg::ST_IDLE;
      rd_ptr_r    <= '0;
      ch_r        <= '0;
      cyc_cnt_r   <= '0;
      stop_pend_r <= 1'b0;
    end else begin
      case (state_r)
        wfm_pkg::ST_IDLE: begin
          if (start_ok) begin
            state_r     <= wfm_pkg::ST_WAIT;
            rd_ptr_r    <= '0;
            cyc_cnt_r   <= '0;
            stop_pend_r <= 1'b0;
          end
        end
        wfm_pkg::ST_WAIT: begin
          if (clear_req) begin
            state_r <= wfm_pkg::ST_IDLE;
          end else if (upd) begin
            state_r <= wfm_pkg::ST_SHIFT;
            ch_r    <= '0;
          end
        end
        wfm_pkg::ST_SHIFT: begin
          if (wrap) begin
            rd_ptr_r  <= '0;
            cyc_cnt_r <= cyc_cnt_r + 1'b1;
          end else begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
          end
          if (hit_end) begin
            stop_pend_r <= 1'b1;
          end
          if (clear_req) begin
            state_r <= wfm_pkg::ST_IDLE;
          end else if (ch_r == CH_LAST) begin
            state_r <= hit_end ? wfm_pkg::ST_IDLE : wfm_pkg::ST_WAIT;
          end else begin
            ch_r <= ch_r + 1'b1;
          end
        end
        default: state_r <= wfm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r     <= 1'b0;
      dac_load_r <= 1'b0;
    end else begin
      last_r     <= (state_r == wfm_pkg::ST_SHIFT) && (ch_r == CH_LAST) && !clear_req;
      dac_load_r <= last_r;
    end
  end

  // codes pass straight through; the converter reads them as offset bipolar
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        hold_r[i]              <= '0;
        dac_code[i*SW +: SW]   <= '0;
      end else begin
        if (state_r == wfm_pkg::ST_SHIFT && ch_r == CH_W'(i)) begin
          hold_r[i] <= wave_r[rd_ptr_r];
        end
        if (last_r) begin
          dac_code[i*SW +: SW] <= hold_r[i];
        end
      end
    end
  end

  assign dac_load    = dac_load_r;
  assign ref_ext_sel = ref_sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_clear_stops;
    @(posedge sys_clk) disable iff (!rst_b)
    clear_req && state_r != wfm_pkg::ST_IDLE |=> state_r == wfm_pkg::ST_IDLE;
  endproperty
  a_clear_stops: assert property (p_clear_stops) else $error("clear did not stop");

  property p_done_count;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(done_r) |-> cycles_r != '0 && cyc_cnt_r == cycles_r;
  endproperty
  a_done_count: assert property (p_done_count) else $error("stopped at wrong count");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_b)
    state_r == wfm_pkg::ST_SHIFT && wrap
      |=> rd_ptr_r == '0 && cyc_cnt_r == $past(cyc_cnt_r) + 1'b1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not counted");

  property p_cyc_range;
    @(posedge sys_clk) disable iff (!rst_b)
    avs_write && avs_address == wfm_pkg::A_CYC && !cyc_ok |=> $stable(cycles_r) && err_r;
  endproperty
  a_cyc_range: assert property (p_cyc_range) else $error("bad count accepted");

  property p_update_load;
    @(posedge sys_clk) disable iff (!rst_b)
    state_r == wfm_pkg::ST_WAIT && upd && !clear_req |-> ##[2:10] dac_load;
  endproperty
  a_update_load: assert property (p_update_load) else $error("update gave no load");

  property p_mem_frozen;
    @(posedge sys_clk) disable iff (!rst_b)
    state_r != wfm_pkg::ST_IDLE |=> $stable(lcnt_r);
  endproperty
  a_mem_frozen: assert property (p_mem_frozen) else $error("memory changed in play");

  // only the idle-to-wait step is a start; shift-to-wait is a normal return
  property p_start_even;
    @(posedge sys_clk) disable iff (!rst_b)
    state_r == wfm_pkg::ST_WAIT && $past(state_r) == wfm_pkg::ST_IDLE
      |-> !$past(lcnt_r[0]) && $past(lcnt_r) != '0 && !$past(dbuf_r) && $past(start_req);
  endproperty
  a_start_even: assert property (p_start_even) else $error("illegal start");

  property p_load_codes;
    @(posedge sys_clk) disable iff (!rst_b)
    dac_load |-> dac_code[SW-1:0] == $past(hold_r[0], 1);
  endproperty
  a_load_codes: assert property (p_load_codes) else $error("code not from hold");

  property p_ref_write;
    @(posedge sys_clk) disable iff (!rst_b)
    !$stable(ref_ext_sel) |-> $past(wr_ctrl);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference moved unasked");

  c_start:  cover property (@(posedge sys_clk) disable iff (!rst_b) start_ok);
  c_wrap:   cover property (@(posedge sys_clk) disable iff (!rst_b)
                            state_r == wfm_pkg::ST_SHIFT && wrap);
  c_done:   cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(done_r));
  c_stall:  cover property (@(posedge sys_clk) disable iff (!rst_b)
                            wr_data && !fifo_in_ready);
endmodule : cyclic_waveform_playback

// ### dv/dac_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// converter bank: every channel latches its code on the load strobe
module dac_model #(
  parameter int NUM_CH = 4
) (
  // clock
  input  wire logic                               sys_clk,
  // from the engine
  input  wire logic [NUM_CH*wfm_pkg::SAMPLE_W-1:0] dac_code,
  input  wire logic                               dac_load,
  input  wire logic                               ref_ext_sel,
  // latched state
  output logic                                    seen,
  output logic      [NUM_CH*wfm_pkg::SAMPLE_W-1:0] held_code,
  output logic                                    held_ref
);
  initial seen = 1'b0;
  // codes are kept raw: bipolar reading is fixed, so no mode to track
  always @(posedge sys_clk) begin
    seen <= (dac_load === 1'b1);
    if (dac_load === 1'b1) begin
      held_code <= dac_code;
      held_ref  <= ref_ext_sel;
    end
  end
endmodule : dac_model

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam int NCH = 4;
  localparam int CW  = NCH * wfm_pkg::SAMPLE_W;
  logic          sys_clk       = 1'b0;
  logic          rst_b         = 1'b0;
  logic [4:0]    avs_address   = 5'h00;
  logic          avs_read      = 1'b0;
  logic          avs_write     = 1'b0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          ext_update    = 1'b0;
  logic [CW-1:0] dac_code;
  logic [CW-1:0] held_code;
  logic          dac_load;
  logic          ref_ext_sel;
  logic          seen;
  logic          held_ref;
  logic          exp_ref       = 1'b0;
  logic [15:0]   lfsr          = 16'h4B45;
  logic [31:0]   rd;
  logic [11:0]   wave[$];
  logic [CW-1:0] exp_q[$];
  int            bad_count     = 0;
  int            comparisons   = 0;
  int            waits;
  int            sw;
  int            nload         = 0;

  always #5 sys_clk = ~sys_clk;

  cyclic_waveform_playback #(.NUM_CH(NCH), .WAVE_DEPTH(64), .FIFO_DEPTH(16)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_update(ext_update), .dac_code(dac_code),
    .dac_load(dac_load), .ref_ext_sel(ref_ext_sel));
  dac_model #(.NUM_CH(NCH)) dac (
    .sys_clk(sys_clk), .dac_code(dac_code), .dac_load(dac_load),
    .ref_ext_sel(ref_ext_sel), .seen(seen), .held_code(held_code), .held_ref(held_ref));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_set(input logic [CW-1:0] exp, input logic [CW-1:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD dac set expected %h seen %h", exp, got);
    end
  endtask : chk_set

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // one bus cycle; entered just after an edge, leaves one edge after release
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 3000);
    if (n >= 3000)
      chk_reg("bus answer", 32'h0, 32'h1);
    rd = avs_readdata;
    waits = n - 1;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_reg(what, exp, rd);
  endtask : rdchk

  task automatic load(input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      wave.push_back(lfsr[11:0]);
      wr(wfm_pkg::A_DATA, {20'h0, lfsr[11:0]});
    end
  endtask : load

  // playback always starts from the first loaded sample
  task automatic expect_upd(input int nupd);
    logic [CW-1:0] s;
    for (int u = 0; u < nupd; u++) begin
      for (int c = 0; c < NCH; c++)
        s[c*12 +: 12] = wave[(u * NCH + c) % wave.size()];
      exp_q.push_back(s);
    end
  endtask : expect_upd

  task automatic pulse;
    ext_update <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ext_update <= 1'b0;
    repeat (27) @(posedge sys_clk);
  endtask : pulse

  always @(posedge sys_clk) begin
    if (seen === 1'b1) begin
      nload++;
      if (exp_q.size() == 0)
        chk_reg("unexpected update", 32'h0, 32'h1);
      else
        chk_set(exp_q.pop_front(), held_code);
      chk_reg("ref select", {31'h0, exp_ref}, {31'h0, held_ref});
    end
  end

  initial begin
    #300us;
    chk_reg("watchdog", 32'h0, 32'h1);
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdchk("div reset", wfm_pkg::A_DIV, 32'h63);
    rdchk("cyc reset", wfm_pkg::A_CYC, 32'h0);
    wr(5'h18, 32'hFFFF);
    rdchk("unmapped", 5'h18, 32'h0);
    // count limits
    wr(wfm_pkg::A_CYC, 32'h1000001);
    rdchk("cyc over", wfm_pkg::A_CYC, 32'h0);
    rdchk("cyc over err", wfm_pkg::A_STAT, 32'h4);
    wr(wfm_pkg::A_STAT, 32'h4);
    wr(wfm_pkg::A_CYC, 32'h1000000);
    rdchk("cyc max", wfm_pkg::A_CYC, 32'h1000000);
    // programmed run, internal pacing, host fills fifo meanwhile
    wr(wfm_pkg::A_DIV, 32'hF);
    wr(wfm_pkg::A_CYC, 32'd20);
    load(8);
    exp_ref = 1'b1;
    expect_upd(40);
    wr(wfm_pkg::A_CTRL, 32'h09);
    rdchk("ctrl", wfm_pkg::A_CTRL, 32'h08);
    sw = 0;
    for (int i = 0; i < 16; i++) begin
      wr(wfm_pkg::A_DATA, i);
      sw += waits;
    end
    chk_reg("fill waits", 32'h0, sw);
    wr(wfm_pkg::A_DATA, 32'h10);
    chk_reg("full stall", 32'h1, {31'h0, waits > 300});
    repeat (30) @(posedge sys_clk);
    rdchk("done stat", wfm_pkg::A_STAT, 32'h1902);
    rdchk("cycles", wfm_pkg::A_CNT, 32'd20);
    chk_reg("missing updates", 32'h0, exp_q.size());
    // odd load and double-buffer start refused
    wr(wfm_pkg::A_STAT, 32'h2);
    wr(wfm_pkg::A_CTRL, 32'h01);
    rdchk("odd start", wfm_pkg::A_STAT, 32'h1904);
    wr(wfm_pkg::A_STAT, 32'h4);
    wr(wfm_pkg::A_CTRL, 32'h20);
    rdchk("flush", wfm_pkg::A_STAT, 32'h0);
    wave.delete();
    load(8);
    wr(wfm_pkg::A_CTRL, 32'h10);
    wr(wfm_pkg::A_CTRL, 32'h11);
    rdchk("dbuf start", wfm_pkg::A_STAT, 32'h0804);
    wr(wfm_pkg::A_CTRL, 32'h00);
    wr(wfm_pkg::A_STAT, 32'h4);
    // endless run, external pacing, stopped by clear
    wr(wfm_pkg::A_CYC, 32'h0);
    exp_ref = 1'b0;
    expect_upd(5);
    wr(wfm_pkg::A_CTRL, 32'h05);
    rdchk("running", wfm_pkg::A_STAT, 32'h0801);
    repeat (5) pulse();
    wr(wfm_pkg::A_CTRL, 32'h06);
    repeat (2) pulse();
    bus(1'b0, wfm_pkg::A_STAT, 32'h0);
    chk_reg("stopped", 32'h0, {31'h0, rd[0]});
    rdchk("endless cycles", wfm_pkg::A_CNT, 32'd2);
    // memory overflow: one word more than the waveform memory holds
    wr(wfm_pkg::A_CTRL, 32'h20);
    for (int i = 0; i < 65; i++)
      wr(wfm_pkg::A_DATA, i);
    repeat (2) @(posedge sys_clk);
    rdchk("overflow", wfm_pkg::A_STAT, 32'h4008);
    chk_reg("update count", 32'd45, nload);
    chk_reg("missing updates", 32'h0, exp_q.size());
    give_verdict();
  end
endmodule : tb_top
